//--- design/cmw_pkg.sv
package cmw_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ              = 100;
  localparam int unsigned BUS_READY_DELAY_US   = 500;
  localparam int unsigned ALERT_PULSE_WIDTH_US = 256;
  localparam int unsigned TIMEOUT_RESET_MS     = 32;
  localparam int unsigned WDT_PERIOD_MS        = 1000;
  localparam int unsigned BUS_READY_CYC        = BUS_READY_DELAY_US * CLK_MHZ;
  localparam int unsigned ALERT_PULSE_CYC      = ALERT_PULSE_WIDTH_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_RESET_CYC    = TIMEOUT_RESET_MS * 1000 * CLK_MHZ;
  localparam int unsigned WDT_PERIOD_CYC       = WDT_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W                = 32;

  // field values
  localparam logic [1:0] BLK_CTL_OFF = 2'h0;
  localparam logic [1:0] BLK_CTL_RST = 2'h0;

  typedef enum logic [2:0]
  {
    MODE_PRESENT     = 3'h0,
    MODE_STANDBY     = 3'h1,
    MODE_BYPASS      = 3'h2,
    MODE_REV_BYPASS  = 3'h3,
    MODE_HALVING     = 3'h4,
    MODE_REV_HALVING = 3'h5
  } cmw_mode_e;

  typedef enum logic [1:0]
  {
    PWR_OFF   = 2'h0,
    PWR_ADDR  = 2'h1,
    PWR_WAIT  = 2'h2,
    PWR_READY = 2'h3
  } cmw_pwr_e;

  typedef struct packed
  {
    logic       charge_run_bit;
    logic       topology_select_bit;
    logic       reverse_dir_bit;
    logic       wireless_ok_in_low_power_bit;
    logic       wireless_ok_detect_bit;
    logic       post_timeout_action_bit;
    logic [1:0] input_blocking_switch_ctl;
  } cmw_cfg_s;

  typedef struct packed
  {
    logic     is_write;
    cmw_cfg_s cfg;
  } cmw_req_s;

  localparam cmw_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, BLK_CTL_RST};

endpackage : cmw_pkg

//--- design/cmw_sync.sv
`timescale 1ns/1ps
module cmw_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : cmw_sync

//--- design/cmw_link_port.sv
`timescale 1ns/1ps
module cmw_link_port
  import cmw_pkg::*;
(
  // link clock and reset
  input  wire logic     link_clk,
  input  wire logic     link_rst,
  // host access
  input  wire logic     host_write,
  input  wire logic     host_read,
  input  wire cmw_cfg_s host_wdata,
  output logic          host_busy,
  output logic          host_nack,
  // crossing to core
  input  wire logic     bus_ready,
  input  wire logic     ack_tgl,
  output logic          req_tgl,
  output cmw_req_s      req_data
);

  logic ready_s;
  logic ack_s;
  logic access;

  cmw_sync #(.WIDTH(2)) u_sync
  (
    .clk (link_clk),
    .rst (link_rst),
    .d   ({bus_ready, ack_tgl}),
    .q   ({ready_s, ack_s})
  );

  assign access    = host_write | host_read;
  assign host_busy = req_tgl ^ ack_s;

  // launch one access at a time, held until the core echoes the toggle
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      req_tgl   <= 1'b0;
      req_data  <= '{1'b0, CFG_RESET};
      host_nack <= 1'b0;
    end
    else
    begin
      host_nack <= access & (~ready_s | host_busy);
      if (access & ready_s & ~host_busy)
      begin
        req_tgl  <= ~req_tgl;
        req_data <= '{host_write, host_wdata};
      end
    end
  end

endmodule : cmw_link_port

//--- design/cmw_ctrl.sv
`timescale 1ns/1ps
module cmw_ctrl
  import cmw_pkg::*;
#(
  parameter int unsigned BUS_READY_CYCLES   = BUS_READY_CYC,
  parameter int unsigned ALERT_CYCLES       = ALERT_PULSE_CYC,
  parameter int unsigned RESET_DELAY_CYCLES = TIMEOUT_RESET_CYC,
  parameter int unsigned WDT_CYCLES         = WDT_PERIOD_CYC
)
(
  // core clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // device pins and analog status
  input  wire logic     enable_n_pin,
  input  wire logic     addr_strap_pin,
  input  wire logic     supply_ok,
  input  wire logic     protect_event,
  input  wire logic     stop_charge_event,
  input  wire logic     input_low_fault,
  input  wire logic     input_present,
  // interrupt pin, open drain
  output logic          int_n_out,
  output logic          int_n_oe,
  // link side host access
  input  wire logic     link_clk,
  input  wire logic     link_rst,
  input  wire logic     host_write,
  input  wire logic     host_read,
  input  wire cmw_cfg_s host_wdata,
  output logic          host_busy,
  output logic          host_nack,
  // status
  output cmw_mode_e     mode,
  output cmw_cfg_s      cfg,
  output logic          convert_en,
  output logic          soft_start,
  output logic          protect_active,
  output logic          wireless_ok_active,
  output logic          bus_ready,
  output logic          slave_addr_sel,
  output logic          watchdog_timeout_state,
  output logic          watchdog_timeout_flag
);

  if (BUS_READY_CYCLES < 3 || ALERT_CYCLES < 8 || RESET_DELAY_CYCLES < 2 || WDT_CYCLES < 2)
  begin : g_bad_count
    $error("cmw_ctrl: timing counts too small");
  end

  function automatic cmw_mode_e decode_mode(input logic en_n, input cmw_cfg_s c);
    cmw_mode_e m;
    m = MODE_PRESENT;
    if (en_n)
      m = MODE_PRESENT;
    else if (!c.charge_run_bit)
      m = MODE_STANDBY;
    else
    begin
      case ({c.topology_select_bit, c.reverse_dir_bit})
        2'h0:    m = MODE_BYPASS;
        2'h1:    m = MODE_REV_BYPASS;
        2'h2:    m = MODE_HALVING;
        default: m = MODE_REV_HALVING;
      endcase
    end
    return m;
  endfunction : decode_mode

  logic              en_n_s;
  logic              strap_s;
  logic              supply_s;
  logic              prot_s;
  logic              stop_s;
  logic              low_s;
  logic              inp_s;
  logic              prot_d_r;
  logic              req_s;
  logic              req_tgl_l;
  logic              req_d_r;
  logic              ack_tgl_r;
  logic              host_evt;
  logic              wdt_expire;
  logic              halt_r;
  cmw_req_s          req_data;
  cmw_pwr_e          pwr_r;
  logic [CNT_W-1:0]  wait_cnt_r;
  logic [CNT_W-1:0]  wdt_cnt_r;
  logic [CNT_W-1:0]  alert_cnt_r;
  logic [CNT_W-1:0]  rdly_cnt_r;

  cmw_sync #(.WIDTH(7)) u_pin_sync
  (
    .clk (ref_clk),
    .rst (rst),
    .d   ({enable_n_pin, addr_strap_pin, supply_ok, protect_event,
           stop_charge_event, input_low_fault, input_present}),
    .q   ({en_n_s, strap_s, supply_s, prot_s, stop_s, low_s, inp_s})
  );

  cmw_link_port u_link
  (
    .link_clk   (link_clk),
    .link_rst   (link_rst),
    .host_write (host_write),
    .host_read  (host_read),
    .host_wdata (host_wdata),
    .host_busy  (host_busy),
    .host_nack  (host_nack),
    .bus_ready  (bus_ready),
    .ack_tgl    (ack_tgl_r),
    .req_tgl    (req_tgl_l),
    .req_data   (req_data)
  );

  cmw_sync #(.WIDTH(1)) u_req_sync
  (
    .clk (ref_clk),
    .rst (rst),
    .d   (req_tgl_l),
    .q   (req_s)
  );

  assign host_evt   = (req_s ^ req_d_r) & bus_ready;
  assign wdt_expire = bus_ready & ~watchdog_timeout_state & (wdt_cnt_r == CNT_W'(WDT_CYCLES - 1));
  assign int_n_out  = 1'b0;
  assign int_n_oe   = (alert_cnt_r != '0);

  // request handshake: capture the held word, then echo the toggle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      req_d_r   <= 1'b0;
      ack_tgl_r <= 1'b0;
    end
    else
    begin
      req_d_r   <= req_s;
      ack_tgl_r <= req_d_r;
    end
  end

  // power-up: strap capture, then ready delay
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pwr_r          <= PWR_OFF;
      wait_cnt_r     <= '0;
      bus_ready      <= 1'b0;
      slave_addr_sel <= 1'b0;
    end
    else if (!supply_s)
    begin
      pwr_r     <= PWR_OFF;
      bus_ready <= 1'b0;
    end
    else
    begin
      case (pwr_r)
        PWR_OFF:
        begin
          pwr_r      <= PWR_ADDR;
          wait_cnt_r <= '0;
        end
        PWR_ADDR:
        begin
          slave_addr_sel <= strap_s;
          pwr_r          <= PWR_WAIT;
        end
        PWR_WAIT:
        begin
          wait_cnt_r <= wait_cnt_r + CNT_W'(1);
          if (wait_cnt_r >= CNT_W'(BUS_READY_CYCLES - 3))
          begin
            pwr_r     <= PWR_READY;
            bus_ready <= 1'b1;
          end
        end
        PWR_READY:
          bus_ready <= 1'b1;
        default:
          pwr_r <= PWR_OFF;
      endcase
    end
  end

  // settings: host writes, timeout actions, delayed default restore
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg <= CFG_RESET;
    else
    begin
      if (host_evt && req_data.is_write)
        cfg <= req_data.cfg;
      if (wdt_expire)
      begin
        if (!cfg.post_timeout_action_bit || mode != MODE_BYPASS)
          cfg.charge_run_bit <= 1'b0;
        if (!cfg.post_timeout_action_bit)
          cfg.input_blocking_switch_ctl <= BLK_CTL_OFF;
      end
      if (rdly_cnt_r == CNT_W'(1))
      begin
        cfg.wireless_ok_in_low_power_bit <= CFG_RESET.wireless_ok_in_low_power_bit;
        cfg.wireless_ok_detect_bit       <= CFG_RESET.wireless_ok_detect_bit;
        cfg.input_blocking_switch_ctl    <= CFG_RESET.input_blocking_switch_ctl;
      end
    end
  end

  // watchdog counter and timeout bits
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wdt_cnt_r              <= '0;
      watchdog_timeout_state <= 1'b0;
      watchdog_timeout_flag  <= 1'b0;
    end
    else
    begin
      if (host_evt)
        wdt_cnt_r <= '0;
      else if (bus_ready && !watchdog_timeout_state && !wdt_expire)
        wdt_cnt_r <= wdt_cnt_r + CNT_W'(1);
      // expiry wins over a host access landing in the same cycle
      if (wdt_expire)
        watchdog_timeout_state <= 1'b1;
      else if (host_evt)
        watchdog_timeout_state <= 1'b0;
      if (wdt_expire)
        watchdog_timeout_flag <= 1'b1;
      else if (host_evt && !req_data.is_write)
        watchdog_timeout_flag <= 1'b0;
    end
  end

  // interrupt pulse and restore delay
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      alert_cnt_r <= '0;
      rdly_cnt_r  <= '0;
      prot_d_r    <= 1'b0;
    end
    else
    begin
      prot_d_r <= prot_s;
      if (wdt_expire || (prot_s && !prot_d_r && mode == MODE_STANDBY))
        alert_cnt_r <= CNT_W'(ALERT_CYCLES);
      else if (alert_cnt_r != '0)
        alert_cnt_r <= alert_cnt_r - CNT_W'(1);
      if (wdt_expire)
        rdly_cnt_r <= CNT_W'(RESET_DELAY_CYCLES);
      else if (rdly_cnt_r != '0)
        rdly_cnt_r <= rdly_cnt_r - CNT_W'(1);
    end
  end

  // mode and conversion control
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode               <= MODE_PRESENT;
      halt_r             <= 1'b0;
      convert_en         <= 1'b0;
      soft_start         <= 1'b0;
      protect_active     <= 1'b0;
      wireless_ok_active <= 1'b0;
    end
    else
    begin
      mode <= decode_mode(en_n_s, cfg);
      if (stop_s && mode == MODE_BYPASS)
        halt_r <= 1'b1;
      else if (halt_r && !low_s && inp_s)
        halt_r <= 1'b0;
      soft_start     <= halt_r && !stop_s && !low_s && inp_s && mode == MODE_BYPASS;
      convert_en     <= mode != MODE_PRESENT && mode != MODE_STANDBY && !halt_r;
      protect_active <= mode != MODE_PRESENT;
      wireless_ok_active <= (mode == MODE_PRESENT) ?
                            (cfg.wireless_ok_in_low_power_bit & cfg.wireless_ok_detect_bit) :
                            cfg.wireless_ok_detect_bit;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  present_mode_a: assert property (en_n_s |=> mode == MODE_PRESENT)
    else $error("present mode not entered");
  standby_mode_a: assert property (!en_n_s && !cfg.charge_run_bit |=> mode == MODE_STANDBY ##1 !convert_en)
    else $error("standby mode wrong");
  run_mode_a: assert property (!en_n_s && cfg.charge_run_bit && cfg.topology_select_bit && !cfg.reverse_dir_bit
                               |=> mode == MODE_HALVING)
    else $error("run mode decode wrong");
  wireless_ok_a: assert property (mode == MODE_PRESENT && !cfg.wireless_ok_in_low_power_bit
                                  |=> !wireless_ok_active && !protect_active)
    else $error("present mode detection active");
  standby_alert_a: assert property (prot_s && !prot_d_r && mode == MODE_STANDBY |=> int_n_oe [*8])
    else $error("standby event without interrupt");
  addr_capture_a: assert property (pwr_r == PWR_ADDR && supply_s |=> slave_addr_sel == $past(strap_s))
    else $error("strap not captured");
  ready_gate_a: assert property ($rose(bus_ready) |-> $past(pwr_r) == PWR_WAIT &&
                                 $past(wait_cnt_r) == CNT_W'(BUS_READY_CYCLES - 3))
    else $error("port opened early");
  timeout_set_a: assert property (wdt_expire |=> watchdog_timeout_state && watchdog_timeout_flag && int_n_oe)
    else $error("timeout bits not set");
  restart_a: assert property (host_evt |=> wdt_cnt_r == '0 && watchdog_timeout_state == $past(wdt_expire))
    else $error("watchdog not restarted");
  post_action_a: assert property (wdt_expire && !cfg.post_timeout_action_bit && !host_evt
                                  |=> !cfg.charge_run_bit && cfg.input_blocking_switch_ctl == BLK_CTL_OFF)
    else $error("post timeout action wrong");
  restore_delay_a: assert property (rdly_cnt_r == CNT_W'(1) && !host_evt
                                    |=> cfg.wireless_ok_detect_bit == CFG_RESET.wireless_ok_detect_bit)
    else $error("defaults not restored");
  halt_keep_a: assert property (stop_s && mode == MODE_BYPASS && !host_evt && !wdt_expire
                                |=> halt_r && $stable(cfg.charge_run_bit) ##1 !convert_en)
    else $error("stop charge handling wrong");
  int_idle_a: assert property ($rose(int_n_oe) |-> $past(wdt_expire) ||
                               ($past(prot_s) && !$past(prot_d_r) && $past(mode) == MODE_STANDBY))
    else $error("interrupt pulled without cause");

  timeout_c:   cover property (wdt_expire ##1 watchdog_timeout_state);
  softstart_c: cover property (halt_r ##[1:50] soft_start);
  ready_c:     cover property ($rose(bus_ready));
  write_c:     cover property (host_evt && req_data.is_write);

endmodule : cmw_ctrl

//--- bench/cmw_host_model.sv
`timescale 1ns/1ps
module cmw_host_model
  import cmw_pkg::*;
(
  // link side
  input  wire logic     link_clk,
  input  wire logic     host_busy,
  input  wire logic     host_nack,
  output logic          host_write,
  output logic          host_read,
  output cmw_cfg_s      host_wdata,
  // interrupt pin, open drain with pull-up
  input  wire logic     int_n_out,
  input  wire logic     int_n_oe,
  output logic          int_line
);
  int alerts;

  // released pin reads high through the pull-up
  assign int_line = int_n_oe ? int_n_out : 1'b1;

  initial
  begin
    host_write = 1'b0;
    host_read  = 1'b0;
    host_wdata = '0;
    alerts     = 0;
  end

  // host catches events on falling edges
  always @(negedge int_line)
    alerts++;

  // one access: one-cycle strobe, then wait until the crossing is done
  task automatic access(input logic wr, input cmw_cfg_s d, output logic nack);
    int n;
    @(posedge link_clk);
    #1;
    host_write = wr;
    host_read  = !wr;
    host_wdata = d;
    @(posedge link_clk);
    #1;
    host_write = 1'b0;
    host_read  = 1'b0;
    host_wdata = ~d;
    nack       = host_nack;
    for (n = 0; n < 64 && host_busy !== 1'b0; n++)
    begin
      @(posedge link_clk);
      #1;
    end
  endtask : access
endmodule : cmw_host_model

//--- bench/charger_mode_watchdog_ctrl_tb_top.sv
`timescale 1ns/1ps
module charger_mode_watchdog_ctrl_tb_top
  import cmw_pkg::*;
;
  localparam int unsigned ALC = 10;
  localparam int unsigned RDC = 40;
  localparam int unsigned WDC = 400;

  logic      ref_clk = 1'b0;
  logic      link_clk = 1'b0;
  logic      rst, link_rst, enable_n_pin, addr_strap_pin, supply_ok;
  logic      protect_event, stop_charge_event, input_low_fault, input_present;
  logic      host_write, host_read, host_busy, host_nack, int_n_out, int_n_oe, int_line;
  cmw_cfg_s  host_wdata, cfg;
  cmw_mode_e mode;
  logic      convert_en, soft_start, protect_active, wireless_ok_active;
  logic      bus_ready, slave_addr_sel, watchdog_timeout_state, watchdog_timeout_flag;
  int        error_cnt, check_count, cyc, n, k, a0;
  logic      nk, s;
  cmw_mode_e exp_m [4] = '{MODE_BYPASS, MODE_REV_BYPASS, MODE_HALVING, MODE_REV_HALVING};

  always #5 ref_clk = ~ref_clk;
  always #80 link_clk = ~link_clk;

  cmw_ctrl #(.BUS_READY_CYCLES(20), .ALERT_CYCLES(ALC), .RESET_DELAY_CYCLES(RDC), .WDT_CYCLES(WDC)) i_dut
  (
    .ref_clk(ref_clk), .rst(rst), .enable_n_pin(enable_n_pin), .addr_strap_pin(addr_strap_pin),
    .supply_ok(supply_ok), .protect_event(protect_event), .stop_charge_event(stop_charge_event),
    .input_low_fault(input_low_fault), .input_present(input_present), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe), .link_clk(link_clk), .link_rst(link_rst), .host_write(host_write),
    .host_read(host_read), .host_wdata(host_wdata), .host_busy(host_busy), .host_nack(host_nack),
    .mode(mode), .cfg(cfg), .convert_en(convert_en), .soft_start(soft_start),
    .protect_active(protect_active), .wireless_ok_active(wireless_ok_active), .bus_ready(bus_ready),
    .slave_addr_sel(slave_addr_sel), .watchdog_timeout_state(watchdog_timeout_state),
    .watchdog_timeout_flag(watchdog_timeout_flag)
  );

  cmw_host_model i_host
  (
    .link_clk(link_clk), .host_busy(host_busy), .host_nack(host_nack), .host_write(host_write),
    .host_read(host_read), .host_wdata(host_wdata), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .int_line(int_line)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] d);
    i_host.access(1'b1, d, nk);
    tick(6);
    chk(8'(nk), 8'h00);
    chk(cfg, d);
  endtask : wr

  task automatic wait_wdt;
    for (n = 0; n < WDC + 300 && watchdog_timeout_state !== 1'b1; n++)
      tick(1);
  endtask : wait_wdt

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // run length guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    rst = 1'b1;
    link_rst = 1'b1;
    enable_n_pin = 1'b1;
    addr_strap_pin = 1'b1;
    supply_ok = 1'b0;
    protect_event = 1'b0;
    stop_charge_event = 1'b0;
    input_low_fault = 1'b0;
    input_present = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge link_clk);
    #1;
    link_rst = 1'b0;
    tick(2);
    chk(8'(mode), 8'(MODE_PRESENT));
    chk(cfg, CFG_RESET);
    chk(8'(int_n_oe), 8'h00);
    chk(8'(bus_ready), 8'h00);
    i_host.access(1'b1, 8'h04, nk);
    chk(8'(nk), 8'h01);
    supply_ok = 1'b1;
    for (n = 0; n < 200 && bus_ready !== 1'b1; n++)
      tick(1);
    chk(8'(n >= 20 && n <= 28), 8'h01);
    chk(8'(slave_addr_sel), 8'(addr_strap_pin));
    tick(100);
    $display("test power up done");
    wr(8'h84);
    chk(8'(mode), 8'(MODE_PRESENT));
    chk(8'(convert_en), 8'h00);
    chk(8'(protect_active), 8'h00);
    wr(8'h1C);
    chk(8'(wireless_ok_active), 8'h01);
    wr(8'h0C);
    chk(8'(wireless_ok_active), 8'h00);
    a0 = i_host.alerts;
    protect_event = 1'b1;
    tick(20);
    protect_event = 1'b0;
    chk(8'(i_host.alerts - a0), 8'h00);
    // protections set and charge run clear before charging starts
    wr(8'h04);
    enable_n_pin = 1'b0;
    tick(6);
    chk(8'(mode), 8'(MODE_STANDBY));
    chk(8'(convert_en), 8'h00);
    chk(8'(protect_active), 8'h01);
    protect_event = 1'b1;
    tick(ALC + 10);
    protect_event = 1'b0;
    chk(8'(i_host.alerts - a0), 8'h01);
    $display("test present and standby done");
    for (k = 0; k < 4; k++)
    begin
      wr(8'h84 | 8'(k << 5));
      chk(8'(mode), 8'(exp_m[k]));
      chk(8'(convert_en), 8'h01);
    end
    $display("test run modes done");
    wr(8'h84);
    input_low_fault = 1'b1;
    stop_charge_event = 1'b1;
    tick(6);
    chk(8'(convert_en), 8'h00);
    chk(8'(cfg.charge_run_bit), 8'h01);
    stop_charge_event = 1'b0;
    tick(10);
    chk(8'(convert_en), 8'h00);
    input_low_fault = 1'b0;
    input_present = 1'b0;
    tick(10);
    chk(8'(convert_en), 8'h00);
    input_present = 1'b1;
    s = 1'b0;
    for (n = 0; n < 20; n++)
    begin
      tick(1);
      s = s | soft_start;
    end
    chk(8'(s), 8'h01);
    chk(8'(convert_en), 8'h01);
    $display("test stop charge done");
    wr(8'h9B);
    wait_wdt();
    chk(8'(watchdog_timeout_state), 8'h01);
    chk(8'(watchdog_timeout_flag), 8'h01);
    for (n = 0; n < 100 && int_n_oe === 1'b1; n++)
      tick(1);
    chk(8'(n), 8'(ALC));
    tick(2);
    chk(8'(mode), 8'(MODE_STANDBY));
    chk(8'(cfg.input_blocking_switch_ctl), 8'h00);
    chk(8'(cfg[4:3]), 8'h03);
    tick(RDC);
    chk(8'(cfg[4:3]), 8'h00);
    i_host.access(1'b0, 8'h00, nk);
    tick(6);
    chk(8'(watchdog_timeout_state), 8'h00);
    chk(8'(watchdog_timeout_flag), 8'h00);
    wr(8'h84);
    wait_wdt();
    tick(4);
    chk(8'(watchdog_timeout_state), 8'h01);
    chk(8'(mode), 8'(MODE_BYPASS));
    $display("test watchdog done");
    complete_run();
  end
endmodule : charger_mode_watchdog_ctrl_tb_top
